// *** design/oam_loss_pkg.sv ***
// package: register map, field positions and widths for the oam loss block
package oam_loss_pkg;

    // ****************************************
    // register word addresses (byte offsets)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL       = 8'h00; // enables and insert-next
    localparam logic [7:0] ADDR_STATUS     = 8'h04; // rx flags and invalid-peer flag, write one to clear
    localparam logic [7:0] ADDR_TX_FCB     = 8'h08; // stored tx far count
    localparam logic [7:0] ADDR_RX_FCB     = 8'h0C; // stored rx far count
    localparam logic [7:0] ADDR_REQ_TX_CNT = 8'h10; // loss request tx counter
    localparam logic [7:0] ADDR_REP_RX_CNT = 8'h14; // loss reply rx counter
    localparam logic [7:0] ADDR_SYN_TX_CNT = 8'h18; // synthetic initiator tx counter
    localparam logic [7:0] ADDR_SYN_PRIO   = 8'h1C; // synthetic priority
    localparam logic [7:0] ADDR_PEER_BASE  = 8'h20; // peer list rows, 4 bytes each
    localparam logic [7:0] ADDR_TX_LM_BASE = 8'h40; // tx loss counters, one per index
    localparam logic [7:0] ADDR_RX_LM_BASE = 8'h60; // rx loss counters, one per index

    // ****************************************
    // control register fields
    // ****************************************
    localparam int CTRL_HW_PROC_BIT   = 0;
    localparam int CTRL_PDU_CNT_BIT   = 1;
    localparam int CTRL_DATA_CNT_BIT  = 2;
    localparam int CTRL_INS_NEXT_BIT  = 3;
    localparam int CTRL_RSV_UPD_BIT   = 4;
    localparam int CTRL_SYN_EN_BIT    = 5;
    localparam int CTRL_SRV_SYN_BIT   = 6;
    localparam int CTRL_PORT_SYN_BIT  = 7;
    localparam int CTRL_CCM_EN_BIT    = 8;
    localparam int CTRL_WIDTH         = 9;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h100;

    // ****************************************
    // status register fields
    // ****************************************
    localparam int STAT_CCM_LM_BIT = 0;
    localparam int STAT_SYN_BIT    = 1;
    localparam int STAT_LMX_BIT    = 2;
    localparam int STAT_INVALID_BIT = 3;
    localparam int STAT_WIDTH      = 4;

    // ****************************************
    // peer list row fields
    // ****************************************
    localparam int PEER_ENA_BIT  = 16;
    localparam int MEPID_WIDTH   = 13;

    // ****************************************
    // frame kinds from the pipeline lookup
    // ****************************************
    typedef enum logic [2:0] {
        PDU_DATA,
        PDU_CCM,
        PDU_LMX,
        PDU_SLM,
        PDU_SLR,
        PDU_SL1
    } pdu_kind_t;

endpackage : oam_loss_pkg

// *** design/oam_loss_endpoint.sv ***
// file: per-endpoint loss measurement counting with a classic wishbone slave
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps

// Behaviour
// - loss pdus always sample counters by class id
// - hw disabled: plain ccm, still set flag
// - ccm-lm pdu counters follow pdu count enable, initiator counter does not
// - data counters include ccm-lm only if enabled
// - ccm with non-zero count field is ccm-lm
// - insert-next flag marks next ccm as ccm-lm
// - tx writes TxFCf, TxFCb, RxFCb fields
// - tx ccm-lm bumps loss request tx counter
// - rx ccm-lm sets flag, stores TxFCf
// - rx ccm-lm samples rx counter as RxFCb
// - optionally write rx sample into reserved
// - rx ccm-lm bumps loss reply rx counter
// - ccm processing stays on for ccm-lm
// - synthetic mode indexes counters by peer index
// - match peer list, else mark frame invalid
// - color gating same as frame loss
// - synthetic pdu on non-synthetic endpoint not counted
// - wrong-type loss pdus still set flag
// - initiator counts slm and 1sl in one counter
// - slr tx per peer tx, slr rx per peer rx
// - 1sl rx per peer rx, tx unused
// - skip server and port counts if synthetic
module oam_loss_endpoint
    import oam_loss_pkg::*;
#(
    parameter int NUM_IDX  = 8,
    parameter int CNT_W    = 32
) (
    input  wire logic              CORE_CLK_I,
    input  wire logic              RESET_N_I,
    // classic wishbone slave
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [7:0]        WB_ADR_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic      [31:0]       WB_DAT_O,
    output logic                   WB_ACK_O,
    // one lookup per cycle from the switch pipeline
    input  wire logic              LKP_VALID_I,
    input  wire logic              LKP_IS_TX_I,
    input  wire pdu_kind_t         LKP_KIND_I,
    input  wire logic [2:0]        LKP_COSID_I,
    input  wire logic              LKP_GREEN_I,
    input  wire logic [MEPID_WIDTH-1:0] LKP_MEPID_I,
    input  wire logic [CNT_W-1:0]  LKP_TXFCF_I,
    input  wire logic [CNT_W-1:0]  LKP_TXFCB_I,
    input  wire logic [CNT_W-1:0]  LKP_RXFCB_I,
    input  wire logic [CNT_W-1:0]  LKP_RSV_I,
    input  wire logic              TIMER_INS_I,
    // registered result of the lookup
    output logic                   RES_VALID_O,
    output logic                   RES_LOSS_PDU_O,
    output logic                   RES_INVALID_O,
    output logic [CNT_W-1:0]       RES_TXFCF_O,
    output logic [CNT_W-1:0]       RES_TXFCB_O,
    output logic [CNT_W-1:0]       RES_RXFCB_O,
    output logic [CNT_W-1:0]       RES_RSV_O,
    output logic                   RES_SRV_CNT_O,
    output logic                   RES_PORT_CNT_O
);

    localparam int IDX_W = $clog2(NUM_IDX);

    // ****************************************
    // state
    // ****************************************
    logic [CTRL_WIDTH-1:0]  ctrl_r;
    logic [STAT_WIDTH-1:0]  stat_r;
    logic [CNT_W-1:0]       tx_fcb_r;
    logic [CNT_W-1:0]       rx_fcb_r;
    logic [CNT_W-1:0]       req_tx_cnt_r;
    logic [CNT_W-1:0]       rep_rx_cnt_r;
    logic [CNT_W-1:0]       syn_tx_cnt_r;
    logic [2:0]             syn_prio_r;
    logic [PEER_ENA_BIT:0]  peer_r   [NUM_IDX];
    logic [CNT_W-1:0]       tx_lm_r  [NUM_IDX];
    logic [CNT_W-1:0]       rx_lm_r  [NUM_IDX];
    logic                   ack_r;
    logic [31:0]            rdat_r;

    // ****************************************
    // control decode
    // ****************************************
    wire hw_en      = ctrl_r[CTRL_HW_PROC_BIT];
    wire pdu_cnt_en = ctrl_r[CTRL_PDU_CNT_BIT];
    wire data_cnt_en = ctrl_r[CTRL_DATA_CNT_BIT];
    wire ins_next   = ctrl_r[CTRL_INS_NEXT_BIT];
    wire rsv_upd_en = ctrl_r[CTRL_RSV_UPD_BIT];
    wire syn_en     = ctrl_r[CTRL_SYN_EN_BIT];
    wire ccm_en     = ctrl_r[CTRL_CCM_EN_BIT];

    // peer match: lowest matching enabled row wins
    function automatic logic [IDX_W:0] peer_lookup(input logic [MEPID_WIDTH-1:0] id,
                                                   input logic [PEER_ENA_BIT:0] tbl [NUM_IDX]);
        logic [IDX_W:0] res;
        res = '0;
        for (int i = NUM_IDX - 1; i >= 0; i--) begin
            if (tbl[i][PEER_ENA_BIT] && tbl[i][MEPID_WIDTH-1:0] == id) begin
                res = {1'b1, IDX_W'(i)};
            end
        end
        return res;
    endfunction : peer_lookup

    // ****************************************
    // lookup classification
    // ****************************************
    wire               is_ccm    = LKP_VALID_I && LKP_KIND_I == PDU_CCM && ccm_en;
    wire               nz_fields = |{LKP_TXFCF_I, LKP_TXFCB_I, LKP_RXFCB_I};
    wire               ccm_lm    = is_ccm && (nz_fields || ins_next);
    wire               lm_act    = ccm_lm && hw_en && !syn_en;
    wire               is_syn    = LKP_VALID_I && (LKP_KIND_I == PDU_SLM ||
                                   LKP_KIND_I == PDU_SLR || LKP_KIND_I == PDU_SL1);
    wire               is_lmx    = LKP_VALID_I && LKP_KIND_I == PDU_LMX;
    wire [IDX_W:0]     peer_hit  = peer_lookup(LKP_MEPID_I, peer_r);
    wire               peer_ok   = peer_hit[IDX_W];
    wire               prio_ok   = LKP_COSID_I == syn_prio_r;
    wire               syn_ok    = is_syn && syn_en && peer_ok && prio_ok;
    // counter index: peer index in synthetic mode, else class id
    wire [IDX_W-1:0]   cnt_idx   = syn_en ? peer_hit[IDX_W-1:0]
                                          : IDX_W'(LKP_COSID_I);
    wire               is_data   = LKP_VALID_I && LKP_KIND_I == PDU_DATA;
    // frame loss data counting: green, not synthetic
    wire               fl_cnt    = !syn_en && LKP_GREEN_I &&
                                   (is_data || (lm_act && data_cnt_en));
    // synthetic per-peer counting by direction
    wire               syn_tx_pp = syn_ok && LKP_GREEN_I && LKP_IS_TX_I &&
                                   LKP_KIND_I == PDU_SLR;
    wire               syn_rx_pp = syn_ok && LKP_GREEN_I && !LKP_IS_TX_I &&
                                   (LKP_KIND_I == PDU_SLR || LKP_KIND_I == PDU_SL1);
    wire               syn_init  = is_syn && syn_en && LKP_IS_TX_I && prio_ok &&
                                   (LKP_KIND_I == PDU_SLM || LKP_KIND_I == PDU_SL1);
    wire               tx_inc    = (fl_cnt && LKP_IS_TX_I) || syn_tx_pp;
    wire               rx_inc    = (fl_cnt && !LKP_IS_TX_I) || syn_rx_pp;
    wire [CNT_W-1:0]   tx_lm_cur = tx_lm_r[cnt_idx];
    wire [CNT_W-1:0]   rx_lm_cur = rx_lm_r[cnt_idx];

    // ****************************************
    // wishbone decode
    // ****************************************
    wire               wb_req    = WB_CYC_I && WB_STB_I && !ack_r;
    wire               wb_wr     = WB_CYC_I && WB_STB_I && ack_r && WB_WE_I;
    wire               sel_peer  = WB_ADR_I[7:5] == ADDR_PEER_BASE[7:5];
    wire               sel_txlm  = WB_ADR_I[7:5] == ADDR_TX_LM_BASE[7:5];
    wire               sel_rxlm  = WB_ADR_I[7:5] == ADDR_RX_LM_BASE[7:5];
    wire [IDX_W-1:0]   wb_idx    = WB_ADR_I[IDX_W+1:2];
    wire               wr_ctrl   = wb_wr && WB_ADR_I == ADDR_CTRL;
    wire               wr_stat   = wb_wr && WB_ADR_I == ADDR_STATUS;
    wire               wr_prio   = wb_wr && WB_ADR_I == ADDR_SYN_PRIO;
    wire [31:0]        wmask     = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                                    {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    wire [31:0]        wdat      = WB_DAT_I & wmask;

    // read mux, unmapped words read as zero
    logic [31:0] rd_mux;
    always_comb begin
        unique case (1'b1)
            WB_ADR_I == ADDR_CTRL:       rd_mux = 32'(ctrl_r);
            WB_ADR_I == ADDR_STATUS:     rd_mux = 32'(stat_r);
            WB_ADR_I == ADDR_TX_FCB:     rd_mux = 32'(tx_fcb_r);
            WB_ADR_I == ADDR_RX_FCB:     rd_mux = 32'(rx_fcb_r);
            WB_ADR_I == ADDR_REQ_TX_CNT: rd_mux = 32'(req_tx_cnt_r);
            WB_ADR_I == ADDR_REP_RX_CNT: rd_mux = 32'(rep_rx_cnt_r);
            WB_ADR_I == ADDR_SYN_TX_CNT: rd_mux = 32'(syn_tx_cnt_r);
            WB_ADR_I == ADDR_SYN_PRIO:   rd_mux = 32'(syn_prio_r);
            sel_peer:                    rd_mux = 32'(peer_r[wb_idx]);
            sel_txlm:                    rd_mux = 32'(tx_lm_r[wb_idx]);
            sel_rxlm:                    rd_mux = 32'(rx_lm_r[wb_idx]);
            default:                     rd_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // bus handshake: ack one cycle after request; writes land with ack
    // ****************************************
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= wb_req;
            rdat_r <= wb_req ? rd_mux : rdat_r;
        end
    end

    // ****************************************
    // control and priority registers; insert-next self-clears on use
    // ****************************************
    logic [CTRL_WIDTH-1:0] ctrl_nxt;
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = (ctrl_r & ~CTRL_WIDTH'(wmask)) | CTRL_WIDTH'(wdat);
        end
        if (ccm_lm && hw_en && ins_next && !nz_fields) begin
            ctrl_nxt[CTRL_INS_NEXT_BIT] = 1'b0;
        end
        if (TIMER_INS_I) begin
            ctrl_nxt[CTRL_INS_NEXT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ctrl_r     <= CTRL_RESET;
            syn_prio_r <= 3'h0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            syn_prio_r <= wr_prio && WB_SEL_I[0] ? WB_DAT_I[2:0] : syn_prio_r;
        end
    end

    // ****************************************
    // sticky rx flags and invalid-peer flag (either direction): set wins over write-one-to-clear
    // ****************************************
    logic [STAT_WIDTH-1:0] stat_set;
    always_comb begin
        stat_set = '0;
        stat_set[STAT_CCM_LM_BIT]  = ccm_lm && !LKP_IS_TX_I;
        stat_set[STAT_SYN_BIT]     = is_syn && !LKP_IS_TX_I;
        stat_set[STAT_LMX_BIT]     = is_lmx && !LKP_IS_TX_I;
        stat_set[STAT_INVALID_BIT] = is_syn && syn_en && !peer_ok;
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~(wr_stat ? STAT_WIDTH'(wdat) : '0)) | stat_set;
        end
    end

    // ****************************************
    // ccm-lm stored far counts and pdu counters
    // ****************************************
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tx_fcb_r     <= '0;
            rx_fcb_r     <= '0;
            req_tx_cnt_r <= '0;
            rep_rx_cnt_r <= '0;
            syn_tx_cnt_r <= '0;
        end else begin
            if (lm_act && !LKP_IS_TX_I) begin
                tx_fcb_r <= LKP_TXFCF_I;
                rx_fcb_r <= rx_lm_cur;
            end
            if (lm_act && LKP_IS_TX_I && pdu_cnt_en) begin
                req_tx_cnt_r <= req_tx_cnt_r + 1'b1;
            end
            if (lm_act && !LKP_IS_TX_I && pdu_cnt_en) begin
                rep_rx_cnt_r <= rep_rx_cnt_r + 1'b1;
            end
            if (syn_init) begin
                syn_tx_cnt_r <= syn_tx_cnt_r + 1'b1;
            end
        end
    end

    // ****************************************
    // loss counters and peer list, one row per index
    // ****************************************
    for (genvar g = 0; g < NUM_IDX; g++) begin : g_row
        wire hit = cnt_idx == IDX_W'(g);
        always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
                tx_lm_r[g] <= '0;
                rx_lm_r[g] <= '0;
                peer_r[g]  <= '0;
            end else begin
                if (hit && tx_inc) begin
                    tx_lm_r[g] <= tx_lm_r[g] + 1'b1;
                end else if (wb_wr && sel_txlm && wb_idx == IDX_W'(g)) begin
                    tx_lm_r[g] <= CNT_W'(wdat);
                end
                if (hit && rx_inc) begin
                    rx_lm_r[g] <= rx_lm_r[g] + 1'b1;
                end else if (wb_wr && sel_rxlm && wb_idx == IDX_W'(g)) begin
                    rx_lm_r[g] <= CNT_W'(wdat);
                end
                if (wb_wr && sel_peer && wb_idx == IDX_W'(g)) begin
                    peer_r[g] <= wdat[PEER_ENA_BIT:0];
                end
            end
        end
    end

    // ****************************************
    // registered lookup result with pdu field updates
    // ****************************************
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RES_VALID_O    <= 1'b0;
            RES_LOSS_PDU_O <= 1'b0;
            RES_INVALID_O  <= 1'b0;
            RES_TXFCF_O    <= '0;
            RES_TXFCB_O    <= '0;
            RES_RXFCB_O    <= '0;
            RES_RSV_O      <= '0;
            RES_SRV_CNT_O  <= 1'b0;
            RES_PORT_CNT_O <= 1'b0;
        end else begin
            RES_VALID_O    <= LKP_VALID_I;
            RES_LOSS_PDU_O <= lm_act;
            RES_INVALID_O  <= is_syn && syn_en && !peer_ok;
            RES_TXFCF_O    <= lm_act && LKP_IS_TX_I ? tx_lm_cur : LKP_TXFCF_I;
            RES_TXFCB_O    <= lm_act && LKP_IS_TX_I ? tx_fcb_r : LKP_TXFCB_I;
            RES_RXFCB_O    <= lm_act && LKP_IS_TX_I ? rx_fcb_r : LKP_RXFCB_I;
            RES_RSV_O      <= lm_act && !LKP_IS_TX_I && rsv_upd_en
                              ? rx_lm_cur : LKP_RSV_I;
            // no hierarchy count into synthetic endpoints
            RES_SRV_CNT_O  <= LKP_VALID_I && LKP_GREEN_I &&
                              !ctrl_r[CTRL_SRV_SYN_BIT];
            RES_PORT_CNT_O <= LKP_VALID_I && LKP_GREEN_I &&
                              !ctrl_r[CTRL_PORT_SYN_BIT];
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = rdat_r;

endmodule : oam_loss_endpoint

// *** tb/oam_loss_assertions.sv ***
// checker: port-level properties of the oam loss endpoint
`timescale 1ns/100ps
module oam_loss_checker
    import oam_loss_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input wire logic             CORE_CLK_I,
    input wire logic             RESET_N_I,
    input wire logic             WB_CYC_I,
    input wire logic             WB_STB_I,
    input wire logic             WB_ACK_O,
    input wire logic             LKP_VALID_I,
    input wire pdu_kind_t        LKP_KIND_I,
    input wire logic [CNT_W-1:0] LKP_TXFCB_I,
    input wire logic [CNT_W-1:0] LKP_RSV_I,
    input wire logic             RES_VALID_O,
    input wire logic             RES_LOSS_PDU_O,
    input wire logic             RES_INVALID_O,
    input wire logic [CNT_W-1:0] RES_TXFCB_O,
    input wire logic [CNT_W-1:0] RES_RSV_O,
    input wire logic             RES_SRV_CNT_O,
    input wire logic             RES_PORT_CNT_O
);
    // ****************************************
    // properties, one clock domain
    // ****************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    // ack one cycle after the taking edge, for one cycle
    chk_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not answered next cycle");
    chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus ack longer than one cycle");
    // every lookup gets a result; flags need one
    chk_res_follow: assert property (LKP_VALID_I |=> RES_VALID_O)
        else $error("lookup without result");
    chk_res_only_valid: assert property
        ((RES_LOSS_PDU_O || RES_INVALID_O || RES_SRV_CNT_O || RES_PORT_CNT_O) |-> RES_VALID_O)
        else $error("result flag without result valid");
    chk_loss_ccm_only: assert property (RES_LOSS_PDU_O |-> $past(LKP_KIND_I) == PDU_CCM)
        else $error("loss pdu flagged on a non-ccm frame");
    chk_invalid_syn: assert property
        (RES_INVALID_O |-> $past(LKP_KIND_I) inside {PDU_SLM, PDU_SLR, PDU_SL1})
        else $error("invalid flag on a non-synthetic frame");
    // data frames pass fields through
    chk_rsv_copy: assert property
        (LKP_VALID_I && LKP_KIND_I == PDU_DATA |=> RES_RSV_O == $past(LKP_RSV_I))
        else $error("reserved field altered on data frame");
    chk_fcb_copy: assert property
        (LKP_VALID_I && LKP_KIND_I == PDU_DATA |=> RES_TXFCB_O == $past(LKP_TXFCB_I))
        else $error("far count field altered on data frame");

    cover property (RES_LOSS_PDU_O);
    cover property (RES_INVALID_O);
    cover property (RES_VALID_O && !RES_SRV_CNT_O && RES_PORT_CNT_O);
endmodule : oam_loss_checker

bind oam_loss_endpoint oam_loss_checker #(.CNT_W(CNT_W)) u_chk (
    .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .LKP_VALID_I(LKP_VALID_I),
    .LKP_KIND_I(LKP_KIND_I), .LKP_TXFCB_I(LKP_TXFCB_I), .LKP_RSV_I(LKP_RSV_I),
    .RES_VALID_O(RES_VALID_O), .RES_LOSS_PDU_O(RES_LOSS_PDU_O),
    .RES_INVALID_O(RES_INVALID_O), .RES_TXFCB_O(RES_TXFCB_O), .RES_RSV_O(RES_RSV_O),
    .RES_SRV_CNT_O(RES_SRV_CNT_O), .RES_PORT_CNT_O(RES_PORT_CNT_O)
);

// *** tb/oam_peer_model.sv ***
// partner: remote endpoint model presenting frames at the lookup port
`timescale 1ns/100ps
module oam_peer_model
    import oam_loss_pkg::*;
(
    input  wire logic              clk_i,
    output logic                   valid_o,
    output logic                   is_tx_o,
    output pdu_kind_t              kind_o,
    output logic [2:0]             cosid_o,
    output logic                   green_o,
    output logic [MEPID_WIDTH-1:0] mepid_o,
    output logic [31:0]            txfcf_o,
    output logic [31:0]            txfcb_o,
    output logic [31:0]            rxfcb_o,
    output logic [31:0]            rsv_o
);
    int gap = 0; // idle cycles before each frame

    initial begin
        {valid_o, is_tx_o, cosid_o, green_o, mepid_o} = '0;
        {txfcf_o, txfcb_o, rxfcb_o, rsv_o} = '0;
        kind_o = PDU_DATA;
    end

    // one frame per call
    task automatic send(input logic t, input pdu_kind_t k, input logic [2:0] c,
                        input logic g, input logic [MEPID_WIDTH-1:0] m,
                        input logic [31:0] f0, f1, f2, r);
        repeat (gap) @(posedge clk_i);
        valid_o <= 1'b1;
        is_tx_o <= t;
        kind_o  <= k;
        cosid_o <= c;
        green_o <= g;
        mepid_o <= m;
        txfcf_o <= f0;
        txfcb_o <= f1;
        rxfcb_o <= f2;
        rsv_o   <= r;
        @(posedge clk_i);
        // released fields show the inverse
        valid_o <= 1'b0;
        {txfcf_o, txfcb_o, rxfcb_o, rsv_o} <= ~{f0, f1, f2, r};
    endtask : send
endmodule : oam_peer_model

// *** tb/testbench.sv ***
// bench: wishbone and lookup driven tests of the oam loss endpoint
`timescale 1ns/100ps
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin \
    num_errors++; $display("unexpected at %0t: %s", $time, m); end end
module testbench;
    import oam_loss_pkg::*;
    logic        clk, rst_n, cyc, stb, we, ack, tmr, lv, ltx, lg;
    logic        rv, rloss, rinv, rsrv, rport;
    logic [7:0]  adr;
    logic [2:0]  lcos;
    logic [12:0] lmep;
    logic [31:0] wdat, rdat, rd, lf0, lf1, lf2, lrsv, rf0, rf1, rf2, rrsv;
    pdu_kind_t   lkind;
    int          num_errors = 0;
    int          compares = 0;

    oam_loss_endpoint #(.NUM_IDX(8), .CNT_W(32)) uut (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .LKP_VALID_I(lv), .LKP_IS_TX_I(ltx),
        .LKP_KIND_I(lkind), .LKP_COSID_I(lcos), .LKP_GREEN_I(lg), .LKP_MEPID_I(lmep),
        .LKP_TXFCF_I(lf0), .LKP_TXFCB_I(lf1), .LKP_RXFCB_I(lf2), .LKP_RSV_I(lrsv),
        .TIMER_INS_I(tmr), .RES_VALID_O(rv), .RES_LOSS_PDU_O(rloss),
        .RES_INVALID_O(rinv), .RES_TXFCF_O(rf0), .RES_TXFCB_O(rf1), .RES_RXFCB_O(rf2),
        .RES_RSV_O(rrsv), .RES_SRV_CNT_O(rsrv), .RES_PORT_CNT_O(rport));

    oam_peer_model u_peer (
        .clk_i(clk), .valid_o(lv), .is_tx_o(ltx), .kind_o(lkind), .cosid_o(lcos),
        .green_o(lg), .mepid_o(lmep), .txfcf_o(lf0), .txfcb_o(lf1), .rxfcb_o(lf2),
        .rsv_o(lrsv));

    // ****************************************
    // access tasks
    // ****************************************
    // classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk);
        while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(rd, e, "register read")
    endtask : chk_rd

    // result checked in the one cycle it stands
    task automatic lk(input logic t, input pdu_kind_t k, input logic [2:0] c, input logic g,
                      input logic [12:0] m = 13'h0,
                      input logic [31:0] f0 = 32'h0, f1 = 32'h0, r = 32'h0);
        u_peer.send(t, k, c, g, m, f0, f1, 32'h0, r);
        @(posedge clk);
        `CHK(rv, 1'b1, "result valid missing")
    endtask : lk

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // watchdog: the tests need under two hundred cycles
    initial begin
        #(50 * 4000);
        num_errors++;
        give_verdict();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        {rst_n, cyc, stb, we, tmr, adr, wdat} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_rd(ADDR_CTRL, 32'h100);
        chk_rd(ADDR_STATUS, 32'h0);
        chk_rd(8'hFC, 32'h0);
        // receive ccm-lm on class 3 with preset counters
        wb(1'b1, ADDR_RX_LM_BASE + 8'h0C, 32'h55);
        wb(1'b1, ADDR_TX_LM_BASE + 8'h0C, 32'h77);
        wb(1'b1, ADDR_CTRL, 32'h103);
        lk(1'b0, PDU_CCM, 3'h3, 1'b1, 13'h0, 32'hA1, 32'h0, 32'hC3);
        `CHK(rloss, 1'b1, "nonzero ccm not loss")
        `CHK(rrsv, 32'hC3, "reserved altered")
        chk_rd(ADDR_TX_FCB, 32'hA1);
        chk_rd(ADDR_RX_FCB, 32'h55);
        chk_rd(ADDR_STATUS, 32'h1);
        chk_rd(ADDR_REP_RX_CNT, 32'h1);
        chk_rd(ADDR_RX_LM_BASE + 8'h0C, 32'h55);
        // timer marks the next all-zero ccm only
        tmr <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        lk(1'b1, PDU_CCM, 3'h3, 1'b1);
        `CHK(rloss, 1'b1, "insert-next ignored")
        `CHK({rf0, rf1, rf2}, {32'h77, 32'hA1, 32'h55}, "tx count fields")
        lk(1'b1, PDU_CCM, 3'h3, 1'b1);
        `CHK(rloss, 1'b0, "insert-next stuck")
        chk_rd(ADDR_REQ_TX_CNT, 32'h1);
        // reserved update, then ccm-lm data counting
        wb(1'b1, ADDR_CTRL, 32'h113);
        lk(1'b0, PDU_CCM, 3'h3, 1'b1, 13'h0, 32'hB2, 32'h1, 32'hC3);
        `CHK(rrsv, 32'h55, "rx sample not in reserved")
        chk_rd(ADDR_TX_FCB, 32'hB2);
        wb(1'b1, ADDR_CTRL, 32'h117);
        lk(1'b0, PDU_CCM, 3'h3, 1'b1, 13'h0, 32'h1);
        chk_rd(ADDR_RX_LM_BASE + 8'h0C, 32'h56);
        chk_rd(ADDR_REP_RX_CNT, 32'h3);
        // hw processing off: plain ccm, flag still set
        wb(1'b1, ADDR_STATUS, 32'hF);
        chk_rd(ADDR_STATUS, 32'h0);
        wb(1'b1, ADDR_CTRL, 32'h100);
        lk(1'b0, PDU_CCM, 3'h3, 1'b1, 13'h0, 32'h5);
        `CHK(rloss, 1'b0, "disabled ccm-lm processed")
        chk_rd(ADDR_STATUS, 32'h1);
        chk_rd(ADDR_REP_RX_CNT, 32'h3);
        chk_rd(ADDR_TX_FCB, 32'h1);
        // synthetic mode with three peers, slow partner
        wb(1'b1, ADDR_PEER_BASE, 32'h10011);
        wb(1'b1, ADDR_PEER_BASE + 8'h04, 32'h10022);
        wb(1'b1, ADDR_PEER_BASE + 8'h08, 32'h10044);
        wb(1'b1, ADDR_CTRL, 32'h120);
        u_peer.gap = 2;
        lk(1'b0, PDU_SL1, 3'h0, 1'b1, 13'h22);
        `CHK(rinv, 1'b0, "known peer refused")
        lk(1'b0, PDU_SL1, 3'h0, 1'b1, 13'h33);
        `CHK(rinv, 1'b1, "unknown peer accepted")
        lk(1'b0, PDU_SLR, 3'h0, 1'b0, 13'h11);
        lk(1'b1, PDU_SLM, 3'h0, 1'b1, 13'h11);
        lk(1'b1, PDU_SLR, 3'h0, 1'b1, 13'h44);
        lk(1'b0, PDU_DATA, 3'h3, 1'b1);
        lk(1'b0, PDU_LMX, 3'h0, 1'b1);
        u_peer.gap = 0;
        chk_rd(ADDR_RX_LM_BASE + 8'h04, 32'h1);
        chk_rd(ADDR_RX_LM_BASE, 32'h0);
        chk_rd(ADDR_SYN_TX_CNT, 32'h1);
        chk_rd(ADDR_TX_LM_BASE + 8'h08, 32'h1);
        chk_rd(ADDR_TX_LM_BASE + 8'h04, 32'h0);
        chk_rd(ADDR_RX_LM_BASE + 8'h0C, 32'h56);
        chk_rd(ADDR_STATUS, 32'hF);
        // hierarchy: synthetic server or port, synthetic pdu on plain endpoint
        wb(1'b1, ADDR_CTRL, 32'h140);
        lk(1'b1, PDU_DATA, 3'h2, 1'b1);
        `CHK({rsrv, rport}, 2'b01, "server count not skipped")
        wb(1'b1, ADDR_CTRL, 32'h180);
        lk(1'b1, PDU_DATA, 3'h2, 1'b1);
        `CHK({rsrv, rport}, 2'b10, "port count not skipped")
        wb(1'b1, ADDR_CTRL, 32'h100);
        lk(1'b0, PDU_SLM, 3'h0, 1'b1, 13'h11);
        `CHK({rsrv, rport}, 2'b11, "synthetic pdu not counted as data")
        chk_rd(ADDR_RX_LM_BASE, 32'h0);
        give_verdict();
    end
endmodule : testbench
